// ===== verilog/dbp_top.sv
/*
 DDR2 device command model: write byte mask path, burst handling,
 explicit and automatic precharge, with an AXI4-Lite register slave.
 Assumes the controller drives commands and write data on CLK.
*/
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dbp_top #(
	parameter int DQ_W = 8
) (
	input  wire logic                  CLK,
	input  wire logic                  RESET_N,
	input  wire logic                  S_AXI_AWVALID,
	output logic                       S_AXI_AWREADY,
	input  wire logic [3:0]            S_AXI_AWADDR,
	input  wire logic                  S_AXI_WVALID,
	output logic                       S_AXI_WREADY,
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	output logic                       S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	output logic [1:0]                 S_AXI_BRESP,
	input  wire logic                  S_AXI_ARVALID,
	output logic                       S_AXI_ARREADY,
	input  wire logic [3:0]            S_AXI_ARADDR,
	output logic                       S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	output logic [31:0]                S_AXI_RDATA,
	output logic [1:0]                 S_AXI_RRESP,
	input  wire logic                  CS_N,
	input  wire logic                  RAS_N,
	input  wire logic                  CAS_N,
	input  wire logic                  WE_N,
	input  wire logic [2:0]            BANK_SEL,
	input  wire logic [13:0]           ADDR,
	input  wire logic [2*DQ_W-1:0]     DQ,
	input  wire logic [2*DQ_W/8-1:0]   WRITE_BYTE_MASK,
	output logic                       ARRAY_WR_STB,
	output logic [2:0]                 ARRAY_WR_BANK,
	output logic [9:0]                 ARRAY_WR_COL,
	output logic [1:0]                 ARRAY_WR_PAIR,
	output logic [2*DQ_W-1:0]          ARRAY_WR_DATA,
	output logic [2*DQ_W/8-1:0]        ARRAY_WR_BYTE_EN,
	output logic [7:0]                 BANK_OPEN,
	output logic [7:0]                 BANK_PRECHARGING,
	output logic [7:0]                 AUTO_PRE_PENDING
);
	localparam int MASK_W = 2 * DQ_W / 8;

	if (DQ_W < 8 || DQ_W % 8 != 0) begin : g_bad_width
		$error("DQ_W must be a positive multiple of 8");
	end

	dbp_bank_if bi ();

	dbp_pkg::dbp_cmd_t cmd;
	logic              aw_held_r;
	logic              w_held_r;
	logic [3:0]        aw_addr_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              do_write;
	logic [2:0]        bl_r;
	logic [2:0]        cl_r;
	logic [2:0]        al_r;
	logic              redundant_read_strobe_r;
	logic [19:0]       tim_r;
	logic [31:0]       mode_word;
	logic [31:0]       mode_nxt;
	logic [31:0]       tim_nxt;
	logic [2:0]        bl_half;
	logic [3:0]        wl;
	logic [4:0]        rtp;
	logic [13:0]       line_r [0:dbp_pkg::LINE_DEPTH-1];
	logic [13:0]       tap;
	logic [1:0]        beats_r;

	function automatic logic [31:0] apply_strb(input logic [31:0] old,
	                                           input logic [31:0] nw,
	                                           input logic [3:0]  strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		apply_strb = res;
	endfunction

	function automatic logic [31:0] reg_read(input logic [3:0] a,
	                                         input logic [31:0] mw,
	                                         input logic [19:0] tw,
	                                         input logic [23:0] st);
		logic [3:0] wa;
		wa = {a[3:2], 2'b00};
		if (wa == dbp_pkg::OFS_MODE) begin
			reg_read = mw;
		end else if (wa == dbp_pkg::OFS_TIMING) begin
			reg_read = {12'h000, tw};
		end else if (wa == dbp_pkg::OFS_STATUS) begin
			reg_read = {8'h00, st};
		end else begin
			reg_read = 32'h0000_0000;
		end
	endfunction

	function automatic logic mapped(input logic [3:0] a);
		logic [3:0] wa;
		wa = {a[3:2], 2'b00};
		mapped = (wa == dbp_pkg::OFS_MODE) || (wa == dbp_pkg::OFS_TIMING) ||
		         (wa == dbp_pkg::OFS_STATUS);
	endfunction

	// Register bus: one write and one read outstanding at a time
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			aw_held_r     <= 1'b0;
			S_AXI_AWREADY <= 1'b1;
			aw_addr_r     <= 4'h0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held_r     <= 1'b1;
			S_AXI_AWREADY <= 1'b0;
			aw_addr_r     <= S_AXI_AWADDR;
		end else if (do_write) begin
			aw_held_r <= 1'b0;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_AWREADY <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			w_held_r     <= 1'b0;
			S_AXI_WREADY <= 1'b1;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held_r     <= 1'b1;
			S_AXI_WREADY <= 1'b0;
			w_data_r     <= S_AXI_WDATA;
			w_strb_r     <= S_AXI_WSTRB;
		end else if (do_write) begin
			w_held_r <= 1'b0;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_WREADY <= 1'b1;
		end
	end

	assign do_write = aw_held_r && w_held_r && !S_AXI_BVALID;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= dbp_pkg::RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= mapped(aw_addr_r) ? dbp_pkg::RESP_OKAY :
			                dbp_pkg::RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= dbp_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RDATA   <= reg_read(S_AXI_ARADDR, mode_word, tim_r,
			                          {bi.pend, bi.prech, bi.open});
			S_AXI_RRESP   <= mapped(S_AXI_ARADDR) ? dbp_pkg::RESP_OKAY :
			                 dbp_pkg::RESP_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID  <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	assign mode_word = {19'h00000, redundant_read_strobe_r, 1'b0, al_r, 1'b0, cl_r, 1'b0, bl_r};
	assign mode_nxt  = apply_strb(mode_word, w_data_r, w_strb_r);
	assign tim_nxt   = apply_strb({12'h000, tim_r}, w_data_r, w_strb_r);
	assign cmd       = dbp_pkg::dbp_cmd_t'({CS_N, RAS_N, CAS_N, WE_N});

	// Mode set on the command pins takes priority over a bus write
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			bl_r <= dbp_pkg::BL4_CODE;
			cl_r <= dbp_pkg::CL_RST;
		end else if (cmd == dbp_pkg::CMD_MRS && BANK_SEL == dbp_pkg::MR_BANK) begin
			bl_r <= ADDR[dbp_pkg::MR_BL_LSB +: 3];
			cl_r <= ADDR[dbp_pkg::MR_CL_LSB +: 3];
		end else if (do_write && {aw_addr_r[3:2], 2'b00} == dbp_pkg::OFS_MODE) begin
			bl_r <= mode_nxt[dbp_pkg::MODE_BL_LSB +: 3];
			cl_r <= mode_nxt[dbp_pkg::MODE_CL_LSB +: 3];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			al_r   <= dbp_pkg::AL_RST;
			redundant_read_strobe_r <= 1'b0;
		end else if (cmd == dbp_pkg::CMD_MRS &&
		             BANK_SEL == dbp_pkg::EMR1_BANK) begin
			al_r   <= ADDR[dbp_pkg::EMR_AL_LSB +: 3];
			redundant_read_strobe_r <= ADDR[dbp_pkg::EMR_REDUNDANT_READ_STROBE_BIT];
		end else if (do_write && {aw_addr_r[3:2], 2'b00} == dbp_pkg::OFS_MODE) begin
			al_r   <= mode_nxt[dbp_pkg::MODE_AL_LSB +: 3];
			redundant_read_strobe_r <= mode_nxt[dbp_pkg::MODE_REDUNDANT_READ_STROBE_BIT];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			tim_r <= dbp_pkg::TIM_RST;
		end else if (do_write &&
		             {aw_addr_r[3:2], 2'b00} == dbp_pkg::OFS_TIMING) begin
			tim_r <= tim_nxt[19:0];
		end
	end

	// Timing derived from the programmed length, never the actual burst
	assign bl_half = (bl_r == dbp_pkg::BL8_CODE) ? 3'h4 : 3'h2;
	assign wl      = {1'b0, al_r} + {1'b0, cl_r} - 4'h1;
	assign rtp     = tim_r[dbp_pkg::TIM_RTP_LSB +: dbp_pkg::TIM_FIELD_W];

	assign bi.act     = (cmd == dbp_pkg::CMD_ACT);
	assign bi.rd      = (cmd == dbp_pkg::CMD_READ);
	assign bi.wr      = (cmd == dbp_pkg::CMD_WRITE);
	assign bi.pre     = (cmd == dbp_pkg::CMD_PRE);
	assign bi.ap      = ADDR[dbp_pkg::PRE_SEL_BIT];
	assign bi.pre_all = ADDR[dbp_pkg::PRE_SEL_BIT];
	assign bi.bank    = BANK_SEL;
	// Prefetch ends at posted delay plus half burst minus two
	assign bi.rd_gap  = {5'h00, al_r} + {5'h00, bl_half} - 8'h02 +
	                    ((rtp > 5'h02) ? {3'h0, rtp} : 8'h02);
	assign bi.wr_gap  = {4'h0, wl} + {5'h00, bl_half} +
	                    {3'h0, tim_r[dbp_pkg::TIM_WR_LSB +:
	                    dbp_pkg::TIM_FIELD_W]};
	assign bi.ras     = tim_r[dbp_pkg::TIM_RAS_LSB +: dbp_pkg::TIM_FIELD_W];
	assign bi.rp      = tim_r[dbp_pkg::TIM_RP_LSB +: dbp_pkg::TIM_FIELD_W];

	dbp_bank_unit u_bank (
		.clk     (CLK),
		.reset_n (RESET_N),
		.bi      (bi)
	);

	// Write commands ride a delay line until write latency elapses
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < dbp_pkg::LINE_DEPTH; i++) begin
				line_r[i] <= 14'h0000;
			end
		end else begin
			line_r[0] <= {bi.wr, BANK_SEL, ADDR[9:0]};
			for (int i = 1; i < dbp_pkg::LINE_DEPTH; i++) begin
				line_r[i] <= line_r[i-1];
			end
		end
	end

	assign tap = line_r[wl - 4'h1];

	// A new tap restarts the beat count, truncating an interrupted burst
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ARRAY_WR_STB     <= 1'b0;
			ARRAY_WR_BANK    <= 3'h0;
			ARRAY_WR_COL     <= 10'h000;
			ARRAY_WR_PAIR    <= 2'h0;
			ARRAY_WR_DATA    <= '0;
			ARRAY_WR_BYTE_EN <= '0;
			beats_r          <= 2'h0;
		end else if (tap[13] || beats_r != 2'h0) begin
			ARRAY_WR_STB     <= 1'b1;
			ARRAY_WR_DATA    <= DQ;
			// Redundant strobe mode reuses the mask pin, so masking is off
			ARRAY_WR_BYTE_EN <= redundant_read_strobe_r ? {MASK_W{1'b1}} : ~WRITE_BYTE_MASK;
			if (tap[13]) begin
				ARRAY_WR_BANK <= tap[12:10];
				ARRAY_WR_COL  <= tap[9:0];
				ARRAY_WR_PAIR <= 2'h0;
				beats_r       <= 2'(bl_half - 3'h1);
			end else begin
				ARRAY_WR_PAIR <= ARRAY_WR_PAIR + 2'h1;
				beats_r       <= beats_r - 2'h1;
			end
		end else begin
			ARRAY_WR_STB     <= 1'b0;
			ARRAY_WR_BYTE_EN <= '0;
		end
	end

	assign BANK_OPEN        = bi.open;
	assign BANK_PRECHARGING = bi.prech;
	assign AUTO_PRE_PENDING = bi.pend;

	a_mask_blocks_byte: assert property (@(posedge CLK) disable iff (!RESET_N)
		((tap[13] || beats_r != 2'h0) && !redundant_read_strobe_r) |=>
		(ARRAY_WR_BYTE_EN == ~$past(WRITE_BYTE_MASK) && ARRAY_WR_DATA == $past(DQ)))
		else $error("masked byte not blocked with its data beat");

	a_redundant_read_strobe_mask_off: assert property (@(posedge CLK) disable iff (!RESET_N)
		(tap[13] && redundant_read_strobe_r) |=> (ARRAY_WR_STB && ARRAY_WR_BYTE_EN == {MASK_W{1'b1}}))
		else $error("mask active while redundant strobe enabled");

	sequence s_bl8_tap;
		tap[13] && bl_r == dbp_pkg::BL8_CODE;
	endsequence
	a_burst_len_eight: assert property (@(posedge CLK) disable iff (!RESET_N)
		(s_bl8_tap ##1 !tap[13] [*3]) |-> (ARRAY_WR_STB && ARRAY_WR_PAIR == 2'h2)
		##1 (ARRAY_WR_STB && ARRAY_WR_PAIR == 2'h3))
		else $error("length-eight write burst not four clocks long");

	a_axi_b_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
		(S_AXI_BVALID && !S_AXI_BREADY) |=> (S_AXI_BVALID && $stable(S_AXI_BRESP)))
		else $error("write response dropped before ready");

	a_axi_r_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
		(S_AXI_RVALID && !S_AXI_RREADY) |=> (S_AXI_RVALID && $stable(S_AXI_RDATA)))
		else $error("read data changed before ready");
endmodule
`default_nettype wire

// ===== verilog/dbp_pkg.sv
/*
 Constants, field layouts and command codes shared by the DDR2 burst,
 precharge and auto-precharge model. Assumes a single 50 MHz command clock.
*/
`default_nettype none
package dbp_pkg;
	localparam int CLK_PERIOD_PS  = 20000;
	localparam int RAS_MIN_NS     = 45;
	localparam int RTP_NS         = 8;
	localparam int RP_NS          = 15;
	localparam int WR_NS          = 15;
	localparam int RAS_MIN_CYC    = (RAS_MIN_NS * 1000 + CLK_PERIOD_PS - 1) /
	                                CLK_PERIOD_PS;
	localparam int RTP_CYC        = (RTP_NS * 1000 + CLK_PERIOD_PS - 1) /
	                                CLK_PERIOD_PS;
	localparam int RP_CYC         = (RP_NS * 1000 + CLK_PERIOD_PS - 1) /
	                                CLK_PERIOD_PS;
	localparam int WR_CYC         = (WR_NS * 1000 + CLK_PERIOD_PS - 1) /
	                                CLK_PERIOD_PS;

	localparam int AXI_ADDR_W     = 4;
	localparam logic [3:0] OFS_MODE   = 4'h0;
	localparam logic [3:0] OFS_TIMING = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int MODE_BL_LSB    = 0;
	localparam int MODE_CL_LSB    = 4;
	localparam int MODE_AL_LSB    = 8;
	localparam int MODE_REDUNDANT_READ_STROBE_BIT  = 12;
	localparam int TIM_FIELD_W    = 5;
	localparam int TIM_RAS_LSB    = 0;
	localparam int TIM_RTP_LSB    = 5;
	localparam int TIM_RP_LSB     = 10;
	localparam int TIM_WR_LSB     = 15;
	localparam logic [19:0] TIM_RST = {5'(WR_CYC), 5'(RP_CYC),
	                                  5'(RTP_CYC), 5'(RAS_MIN_CYC)};

	localparam int MR_BL_LSB      = 0;
	localparam int MR_CL_LSB      = 4;
	localparam int EMR_AL_LSB     = 3;
	localparam int EMR_REDUNDANT_READ_STROBE_BIT   = 11;
	localparam int PRE_SEL_BIT    = 10;
	localparam logic [2:0] MR_BANK   = 3'h0;
	localparam logic [2:0] EMR1_BANK = 3'h1;
	localparam logic [2:0] BL4_CODE  = 3'h2;
	localparam logic [2:0] BL8_CODE  = 3'h3;
	localparam logic [2:0] CL_RST    = 3'h3;
	localparam logic [2:0] AL_RST    = 3'h0;
	localparam int LINE_DEPTH     = 16;
	localparam int NUM_BANKS      = 8;

	typedef enum logic [3:0] {
		CMD_MRS   = 4'b0000,
		CMD_PRE   = 4'b0010,
		CMD_ACT   = 4'b0011,
		CMD_WRITE = 4'b0100,
		CMD_READ  = 4'b0101
	} dbp_cmd_t;
endpackage
`default_nettype wire

// ===== verilog/dbp_bank_if.sv
/*
 Command and status bundle between the command decoder and the bank tracker.
 Assumes both ends run on the same command clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbp_bank_if;
	logic       act;
	logic       rd;
	logic       wr;
	logic       pre;
	logic       ap;
	logic       pre_all;
	logic [2:0] bank;
	logic [7:0] rd_gap;
	logic [7:0] wr_gap;
	logic [4:0] ras;
	logic [4:0] rp;
	logic [7:0] open;
	logic [7:0] prech;
	logic [7:0] pend;
	modport ctl (output act, rd, wr, pre, ap, pre_all, bank, rd_gap, wr_gap,
	             ras, rp, input open, prech, pend);
	modport unit (input act, rd, wr, pre, ap, pre_all, bank, rd_gap, wr_gap,
	              ras, rp, output open, prech, pend);
endinterface
`default_nettype wire

// ===== verilog/dbp_bank_unit.sv
/*
 Per-bank open/precharge tracking with auto-precharge scheduling.
 Assumes gaps, ras and rp are at least one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module dbp_bank_unit (
	input  wire logic  clk,
	input  wire logic  reset_n,
	dbp_bank_if.unit   bi
);
	logic [7:0] open_r;
	logic [7:0] prech_r;
	logic [7:0] pend_r;
	logic [7:0] ras_cnt_r [0:dbp_pkg::NUM_BANKS-1];
	logic [7:0] col_cnt_r [0:dbp_pkg::NUM_BANKS-1];
	logic [7:0] rp_cnt_r  [0:dbp_pkg::NUM_BANKS-1];
	logic [7:0] hit;
	logic [7:0] pre_hit;
	logic [7:0] start;

	function automatic logic [7:0] max8(input logic [7:0] a,
	                                    input logic [7:0] b);
		max8 = (a > b) ? a : b;
	endfunction

	assign hit = 8'h01 << bi.bank;
	assign pre_hit = bi.pre ? (bi.pre_all ? 8'hFF : hit) : 8'h00;

	always_comb begin
		for (int b = 0; b < dbp_pkg::NUM_BANKS; b++) begin
			start[b] = pre_hit[b] || (pend_r[b] && col_cnt_r[b] == 8'h00 &&
			           ras_cnt_r[b] == 8'h00);
		end
	end

	always_ff @(posedge clk) begin
		for (int b = 0; b < dbp_pkg::NUM_BANKS; b++) begin
			if (!reset_n) begin
				open_r[b] <= 1'b0;
			end else if (bi.act && hit[b]) begin
				open_r[b] <= 1'b1;
			end else if (start[b]) begin
				open_r[b] <= 1'b0;
			end
		end
	end

	// New auto-precharge request wins over a start in the same cycle
	always_ff @(posedge clk) begin
		for (int b = 0; b < dbp_pkg::NUM_BANKS; b++) begin
			if (!reset_n) begin
				pend_r[b] <= 1'b0;
			end else if ((bi.rd || bi.wr) && bi.ap && hit[b]) begin
				pend_r[b] <= 1'b1;
			end else if (start[b]) begin
				pend_r[b] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int b = 0; b < dbp_pkg::NUM_BANKS; b++) begin
			if (!reset_n) begin
				ras_cnt_r[b] <= 8'h00;
			end else if (bi.act && hit[b]) begin
				ras_cnt_r[b] <= {3'h0, bi.ras} - 8'h01;
			end else if (ras_cnt_r[b] != 8'h00) begin
				ras_cnt_r[b] <= ras_cnt_r[b] - 8'h01;
			end
		end
	end

	// Keep the later deadline so a same-bank interrupt never shortens it
	always_ff @(posedge clk) begin
		for (int b = 0; b < dbp_pkg::NUM_BANKS; b++) begin
			if (!reset_n) begin
				col_cnt_r[b] <= 8'h00;
			end else if (bi.rd && hit[b]) begin
				col_cnt_r[b] <= max8(col_cnt_r[b], bi.rd_gap - 8'h01);
			end else if (bi.wr && hit[b]) begin
				col_cnt_r[b] <= max8(col_cnt_r[b], bi.wr_gap - 8'h01);
			end else if (col_cnt_r[b] != 8'h00) begin
				col_cnt_r[b] <= col_cnt_r[b] - 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int b = 0; b < dbp_pkg::NUM_BANKS; b++) begin
			if (!reset_n) begin
				prech_r[b]  <= 1'b0;
				rp_cnt_r[b] <= 8'h00;
			end else if (start[b]) begin
				prech_r[b]  <= 1'b1;
				rp_cnt_r[b] <= {3'h0, bi.rp} - 8'h01;
			end else if (rp_cnt_r[b] != 8'h00) begin
				rp_cnt_r[b] <= rp_cnt_r[b] - 8'h01;
			end else begin
				prech_r[b] <= 1'b0;
			end
		end
	end

	assign bi.open  = open_r;
	assign bi.prech = prech_r;
	assign bi.pend  = pend_r;

	a_act_opens_bank: assert property (@(posedge clk) disable iff (!reset_n)
		bi.act |=> open_r[$past(bi.bank)])
		else $error("activate did not open bank");

	a_pre_all_closes: assert property (@(posedge clk) disable iff (!reset_n)
		(bi.pre && bi.pre_all && !bi.act) |=> (open_r == 8'h00 &&
		prech_r == 8'hFF))
		else $error("precharge all did not close every bank");

	for (genvar g = 0; g < dbp_pkg::NUM_BANKS; g++) begin : g_chk
		sequence s_ras_busy;
			pend_r[g] && ras_cnt_r[g] > 8'h01 && !pre_hit[g];
		endsequence
		sequence s_still_busy;
			!pre_hit[g] && !(bi.act && hit[g]);
		endsequence
		a_ap_waits_ras: assert property (@(posedge clk)
			disable iff (!reset_n)
			(s_ras_busy ##0 s_still_busy) |=> !$rose(prech_r[g]) ##0 pend_r[g])
			else $error("auto-precharge started before row active time");
		a_pend_clears: assert property (@(posedge clk) disable iff (!reset_n)
			(start[g] && !((bi.rd || bi.wr) && bi.ap && hit[g])) |=>
			(!pend_r[g] && prech_r[g] && !open_r[g]))
			else $error("pending auto-precharge not cleared on start");
		a_rp_holds: assert property (@(posedge clk) disable iff (!reset_n)
			(prech_r[g] && rp_cnt_r[g] != 8'h00) |=> prech_r[g])
			else $error("bank left precharge before row precharge time");
	end
endmodule
`default_nettype wire

// ===== test/dbp_ctl_model.sv
/*
 Controller-side model: drives command pins, write data and byte mask.
 Assumes tasks are called right after a rising CLK edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dbp_ctl_model #(
	parameter int DQ_W = 8
) (
	input  wire logic           clk,
	output logic [3:0]          cmd_n,
	output logic [2:0]          bank,
	output logic [13:0]         addr,
	output logic [2*DQ_W-1:0]   dq,
	output logic [2*DQ_W/8-1:0] mask
);
	localparam int MW = 2 * DQ_W / 8;
	initial begin
		cmd_n = 4'hF;
		{bank, addr, dq, mask} = '0;
	end
	// One command cycle; pins scrambled after so stale values never help
	task automatic cmd(input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a);
		@(posedge clk);
		cmd_n <= c;
		bank <= b;
		addr <= a;
		@(posedge clk);
		cmd_n <= 4'hF;
		bank <= ~b;
		addr <= ~a;
	endtask
	// Never interrupted: burst runs whole before the next command
	task automatic wr(input logic [2:0] b, input logic [13:0] a,
		input int n, input logic [8*DQ_W-1:0] d, input logic [4*MW-1:0] m,
		input int wl);
		cmd(dbp_pkg::CMD_WRITE, b, a);
		// First beat must stand at the edge write latency after the command
		repeat (wl - 1) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			dq <= d[i*2*DQ_W +: 2*DQ_W];
			mask <= m[i*MW +: MW];
			@(posedge clk);
		end
		dq <= ~dq;
		mask <= ~mask;
	endtask
endmodule
`default_nettype wire

// ===== test/tb_dbp_top.sv
/*
 Self-checking bench: bus master, controller model, array write monitor.
 Assumes the package and the controller model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dbp_top;
	logic        clk, rst_n, awv, wv, bq, arv, rq;
	logic [3:0]  awa, ara;
	logic [31:0] wd;
	wire logic   awr, wrd, bv, arr, rv, stb;
	wire logic [1:0]  br, rr, pr, ben, msk;
	wire logic [31:0] rd;
	wire logic [3:0]  cn;
	wire logic [2:0]  bs, wbk;
	wire logic [13:0] ad;
	wire logic [15:0] dq, wdt;
	wire logic [9:0]  col;
	wire logic [7:0]  opn, pre, pnd;
	int err_total, checks_done, cyc;
	int wlat = 2;
	logic [32:0] exp_q[$];
	dbp_top dut (.CLK(clk), .RESET_N(rst_n), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bq), .S_AXI_BRESP(br),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rq), .S_AXI_RDATA(rd),
		.S_AXI_RRESP(rr), .CS_N(cn[3]), .RAS_N(cn[2]), .CAS_N(cn[1]),
		.WE_N(cn[0]), .BANK_SEL(bs), .ADDR(ad), .DQ(dq),
		.WRITE_BYTE_MASK(msk), .ARRAY_WR_STB(stb), .ARRAY_WR_BANK(wbk),
		.ARRAY_WR_COL(col), .ARRAY_WR_PAIR(pr), .ARRAY_WR_DATA(wdt),
		.ARRAY_WR_BYTE_EN(ben), .BANK_OPEN(opn), .BANK_PRECHARGING(pre),
		.AUTO_PRE_PENDING(pnd));
	dbp_ctl_model ctl (.clk(clk), .cmd_n(cn), .bank(bs), .addr(ad),
		.dq(dq), .mask(msk));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			final_report;
		end
	end
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		{awv, wv, bq} <= 3'h7;
		awa <= a;
		wd <= d;
		do begin
			@(posedge clk);
			awv <= awv && (awr !== 1'b1);
			wv <= wv && (wrd !== 1'b1);
		end while (bv !== 1'b1);
		bq <= 1'b0;
		cmp({31'h0, br}, {31'h0, er});
	endtask
	task automatic reg_chk(input logic [3:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge clk);
		{arv, rq} <= 2'h3;
		ara <= a;
		do begin
			@(posedge clk);
			arv <= arv && (arr !== 1'b1);
		end while (rv !== 1'b1);
		rq <= 1'b0;
		cmp({1'b0, rd}, {1'b0, e});
		cmp({31'h0, rr}, {31'h0, er});
	endtask
	task automatic bchk(input logic [7:0] o, p, q);
		#1;
		cmp({9'h0, opn, pre, pnd}, {9'h0, o, p, q});
	endtask
	// Start edge k after return, then precharging holds rp cycles
	task automatic ap_chk(input int b, k, rp);
		logic [7:0] m;
		m = 8'h1 << b;
		repeat (k - 1) @(posedge clk);
		bchk(m, 8'h0, m);
		@(posedge clk);
		bchk(8'h0, m, 8'h0);
		repeat (rp) @(posedge clk);
		bchk(8'h0, 8'h0, 8'h0);
	endtask
	task automatic wr_chk(input logic [2:0] b, input int n, input bit ap,
		input bit full);
		logic [63:0] d;
		logic [7:0]  m;
		logic [9:0]  c;
		d = {$urandom, $urandom};
		m = 8'($urandom);
		c = 10'($urandom);
		for (int i = 0; i < n; i++)
			exp_q.push_back({b, c, 2'(i), d[i*16 +: 16],
				full ? 2'h3 : ~m[i*2 +: 2]});
		ctl.wr(b, {3'h0, ap, c}, n, d, m, wlat);
	endtask
	always @(posedge clk) begin
		#1;
		if (stb === 1'b1)
			cmp({wbk, col, pr, wdt, ben},
				exp_q.size() ? exp_q.pop_front() : 'x);
	end
	initial begin
		int b;
		{rst_n, awv, wv, bq, arv, rq, awa, ara, wd} = '0;
		b = $urandom(46);
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		reg_chk(dbp_pkg::OFS_MODE, 32'h32, 2'h0);
		reg_chk(dbp_pkg::OFS_TIMING, 32'h8423, 2'h0);
		reg_chk(4'hC, 32'h0, 2'h2);
		$display("registers done");
		for (int i = 0; i < 8; i++)
			ctl.cmd(dbp_pkg::CMD_ACT, 3'(i), 14'h0);
		bchk(8'hFF, 8'h0, 8'h0);
		b = $urandom % 8;
		ctl.cmd(dbp_pkg::CMD_PRE, 3'(b), 14'h0);
		bchk(~(8'h1 << b), 8'h1 << b, 8'h0);
		ctl.cmd(dbp_pkg::CMD_PRE, 3'(b + 1), 14'h400);
		bchk(8'h0, 8'hFF, 8'h0);
		repeat (2) @(posedge clk);
		bchk(8'h0, 8'h0, 8'h0);
		$display("precharge done");
		wr_chk(3'h2, 2, 0, 0);
		axi_wr(dbp_pkg::OFS_MODE, 32'h1032, 2'h0);
		wr_chk(3'h6, 2, 0, 1);
		ctl.cmd(dbp_pkg::CMD_MRS, 3'h0, 14'h33);
		reg_chk(dbp_pkg::OFS_MODE, 32'h1033, 2'h0);
		wr_chk(3'h1, 4, 0, 1);
		// Posted delay one: write latency grows to three
		ctl.cmd(dbp_pkg::CMD_MRS, 3'h1, 14'h0008);
		reg_chk(dbp_pkg::OFS_MODE, 32'h133, 2'h0);
		wlat = 3;
		wr_chk(3'h3, 4, 0, 0);
		wlat = 2;
		axi_wr(dbp_pkg::OFS_MODE, 32'h32, 2'h0);
		$display("write mask done");
		// ras 10, rtp 4, rp 3, wr 1
		axi_wr(dbp_pkg::OFS_TIMING, 32'h8C8A, 2'h0);
		ctl.cmd(dbp_pkg::CMD_ACT, 3'h5, 14'h0);
		ctl.cmd(dbp_pkg::CMD_READ, 3'h5, 14'h400);
		ap_chk(5, 8, 3);
		ctl.cmd(dbp_pkg::CMD_ACT, 3'h4, 14'h0);
		repeat (10) @(posedge clk);
		ctl.cmd(dbp_pkg::CMD_READ, 3'h4, 14'h400);
		ap_chk(4, 4, 3);
		ctl.cmd(dbp_pkg::CMD_ACT, 3'h7, 14'h0);
		repeat (10) @(posedge clk);
		wr_chk(3'h7, 2, 1, 0);
		ap_chk(7, 2, 3);
		axi_wr(4'hC, 32'hFFFF, 2'h2);
		reg_chk(dbp_pkg::OFS_TIMING, 32'h8C8A, 2'h0);
		reg_chk(dbp_pkg::OFS_STATUS, 32'h0, 2'h0);
		$display("auto precharge done");
		repeat (4) @(posedge clk);
		cmp(33'(exp_q.size()), 33'h0);
		final_report;
	end
endmodule
`default_nettype wire
